// >>> rtl/charger_config_regs.sv
// charger configuration registers with decoded control outputs
`timescale 1ns/1ps
`default_nettype none
module charger_config_regs
  #(
  parameter bit HAS_DATA_SELECT = 1'b0
  )
  (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register access
  input wire charger_cfg_pkg::reg_req_type req_i,
  output charger_cfg_pkg::reg_rsp_type rsp_o,
  // reset sources
  input wire logic reg_reset_i,
  input wire logic wd_expire_i,
  // watchdog timer handshake
  input wire logic wd_restart_done_i,
  output logic wd_restart_o,
  // charger state
  input wire charger_cfg_pkg::sys_state_type sys_i,
  // control outputs
  output charger_cfg_pkg::ctrl_out_type ctrl_o
  );
  import charger_cfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cfg_a_type cfg_a;
    cfg_b_type cfg_b;
    reg_rsp_type rsp;
    ctrl_out_type ctrl;
    logic restart;
  } regs_type;

  localparam regs_type REGS_RESET = '{
    cfg_a: cfg_a_type'(CHARGER_CONFIG_A_RESET),
    cfg_b: cfg_b_type'(CHARGE_CURRENT_CTRL_RESET),
    rsp: '{ack: 1'b0, rdata: UNMAPPED_READ_VALUE},
    ctrl: '0,
    restart: 1'b0
  };

  regs_type st_reg;
  regs_type st_next;

  logic wr_a;
  logic wr_b;
  logic kick_write;
  logic kick_pending;
  logic [6:0] clamped_code;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [12:0] current_ma(input logic [6:0] code);
    current_ma = 13'(code) * FAST_CHARGE_STEP_MA;
  endfunction

  function automatic logic [11:0] sys_mv(input logic [2:0] code);
    sys_mv = MIN_SYSTEM_OFFSET_MV + 12'(code) * MIN_SYSTEM_STEP_MV;
  endfunction

  // ----------------------------------------------------------------
  // fields restored by watchdog expiry
  // ----------------------------------------------------------------
  // voltage limits and the out_ctrl bit survive expiry; the boost and charge enables are restored
  function automatic cfg_a_type expire_cfg_a
    (
    input cfg_a_type cur
    );
    cfg_a_type res;
    res = cur;
    res.watchdog_kick = CHARGER_CONFIG_A_RESET[WATCHDOG_KICK_BIT];
    res.boost_output_en = CHARGER_CONFIG_A_RESET[BOOST_OUTPUT_EN_BIT];
    res.charge_en = CHARGER_CONFIG_A_RESET[CHARGE_EN_BIT];
    expire_cfg_a = res;
  endfunction

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  // reads see the stored value, before a write of the same cycle;
  // unmapped addresses read as zero
  function automatic logic [7:0] read_mux
    (
    input logic [7:0] addr,
    input cfg_a_type cur_a,
    input cfg_b_type cur_b
    );
    logic [7:0] val;
    val = UNMAPPED_READ_VALUE;
    case (addr)
      CHARGER_CONFIG_A_ADDR:
      begin
        val = cur_a;
      end
      CHARGE_CURRENT_CTRL_ADDR:
      begin
        val = cur_b;
      end
      default:
      begin
        val = UNMAPPED_READ_VALUE;
      end
    endcase
    read_mux = val;
  endfunction

  // ----------------------------------------------------------------
  // threshold select and pulse gating
  // ----------------------------------------------------------------
  // a set bit selects the lower falling threshold
  function automatic logic [11:0] vbat_mv
    (
    input logic sel
    );
    vbat_mv = sel ? MIN_VBAT_LOW_MV : MIN_VBAT_HIGH_MV;
  endfunction

  // pulse requests pass only while the enable bit is set
  function automatic logic pulse_gate
    (
    input logic enable,
    input logic request
    );
    pulse_gate = enable && request;
  endfunction

  // ----------------------------------------------------------------
  // variant-specific output levels
  // ----------------------------------------------------------------
  // adapter-present variant: high only in boost mode with the bit set,
  // low with an adapter and on battery alone
  function automatic logic adapter_level
    (
    input logic boost_on,
    input logic plugged,
    input logic ctrl_bit
    );
    adapter_level = boost_on && !plugged && ctrl_bit;
  endfunction

  // data-select variant: detection or force bit with an adapter,
  // force bit in boost mode, low on battery alone
  function automatic logic data_select_level
    (
    input logic boost_on,
    input logic plugged,
    input logic detecting,
    input logic force_bit
    );
    logic level;
    level = 1'b0;
    if (plugged)
    begin
      level = detecting || force_bit;
    end
    else if (boost_on)
    begin
      level = force_bit;
    end
    data_select_level = level;
  endfunction

  // ----------------------------------------------------------------
  // write decode and submodules
  // ----------------------------------------------------------------
  assign wr_a = req_i.wr && (req_i.addr == CHARGER_CONFIG_A_ADDR);
  assign wr_b = req_i.wr && (req_i.addr == CHARGE_CURRENT_CTRL_ADDR);
  assign kick_write = wr_a && req_i.wdata[WATCHDOG_KICK_BIT];

  current_code_clamp u_clamp
  (
    .code_i(req_i.wdata[FAST_CHARGE_CURRENT_LSB +: 7]),
    .code_o(clamped_code)
  );

  watchdog_kick_tracker u_kick
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .kick_i(kick_write),
    .clear_i(reg_reset_i || wd_expire_i),
    .restart_done_i(wd_restart_done_i),
    .kick_pending_o(kick_pending)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_a_type a;
    cfg_b_type b;
    a = st_reg.cfg_a;
    b = st_reg.cfg_b;
    st_next = st_reg;

    // register writes
    if (wr_a)
    begin
      a = cfg_a_type'(req_i.wdata);
    end
    if (wr_b)
    begin
      b.pulse_control_en = req_i.wdata[PULSE_CONTROL_EN_BIT];
      b.fast_charge_current = clamped_code;
    end
    a.watchdog_kick = kick_pending || kick_write;

    // reset sources override writes
    if (reg_reset_i)
    begin
      a = cfg_a_type'(CHARGER_CONFIG_A_RESET);
      b = cfg_b_type'(CHARGE_CURRENT_CTRL_RESET);
    end
    else if (wd_expire_i)
    begin
      a = expire_cfg_a(a);
      b = cfg_b_type'(CHARGE_CURRENT_CTRL_RESET);
    end
    st_next.cfg_a = a;
    st_next.cfg_b = b;

    // read path
    st_next.rsp.ack = req_i.rd || req_i.wr;
    st_next.rsp.rdata = UNMAPPED_READ_VALUE;
    if (req_i.rd)
    begin
      st_next.rsp.rdata = read_mux(req_i.addr, st_reg.cfg_a, st_reg.cfg_b);
    end

    // restart request to the watchdog timer
    st_next.restart = a.watchdog_kick;

    // decoded controls, taken from the updated fields, not the stored ones
    st_next.ctrl.boost_output_en = a.boost_output_en;
    st_next.ctrl.charge_en = a.charge_en &&
      (b.fast_charge_current != FAST_CHARGE_CODE_OFF);
    st_next.ctrl.min_system_voltage = a.min_system_voltage;
    st_next.ctrl.min_system_mv = sys_mv(a.min_system_voltage);
    st_next.ctrl.min_vbat_sel = a.min_vbat_sel;
    st_next.ctrl.min_vbat_mv = vbat_mv(a.min_vbat_sel);
    st_next.ctrl.pulse_control_en = b.pulse_control_en;
    st_next.ctrl.pulse_up =
      pulse_gate(b.pulse_control_en, sys_i.pulse_up);
    st_next.ctrl.pulse_down =
      pulse_gate(b.pulse_control_en, sys_i.pulse_down);
    st_next.ctrl.fast_charge_current = b.fast_charge_current;
    st_next.ctrl.fast_charge_ma = current_ma(b.fast_charge_current);

    // variant-specific outputs
    st_next.ctrl.adapter_present_out = 1'b0;
    st_next.ctrl.data_select_out = 1'b0;
    if (HAS_DATA_SELECT)
    begin
      st_next.ctrl.data_select_out = data_select_level(a.boost_output_en,
        sys_i.adapter_plugged, sys_i.detect_active, a.out_ctrl);
    end
    else
    begin
      st_next.ctrl.adapter_present_out = adapter_level(a.boost_output_en,
        sys_i.adapter_plugged, a.out_ctrl);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= REGS_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rsp_o = st_reg.rsp;
  assign ctrl_o = st_reg.ctrl;
  assign wd_restart_o = st_reg.restart;

endmodule
`default_nettype wire

// >>> rtl/charger_cfg_pkg.sv
// package: register map, field layout, reset values and carrier types
package charger_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CHARGER_CONFIG_A_ADDR = 8'h03;
  localparam logic [7:0] CHARGE_CURRENT_CTRL_ADDR = 8'h04;
  localparam logic [7:0] CHARGER_CONFIG_A_RESET = 8'h1a;
  localparam logic [7:0] CHARGE_CURRENT_CTRL_RESET = 8'h20;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OUT_CTRL_BIT = 7;
  localparam int WATCHDOG_KICK_BIT = 6;
  localparam int BOOST_OUTPUT_EN_BIT = 5;
  localparam int CHARGE_EN_BIT = 4;
  localparam int MIN_SYSTEM_VOLTAGE_LSB = 1;
  localparam int MIN_VBAT_SEL_BIT = 0;
  localparam int PULSE_CONTROL_EN_BIT = 7;
  localparam int FAST_CHARGE_CURRENT_LSB = 0;

  // ----------------------------------------------------------------
  // scaling of the coded fields
  // ----------------------------------------------------------------
  localparam logic [6:0] FAST_CHARGE_CODE_MAX = 7'h3f;
  localparam logic [6:0] FAST_CHARGE_CODE_OFF = 7'h00;
  localparam logic [12:0] FAST_CHARGE_STEP_MA = 13'h0040;
  localparam logic [11:0] MIN_SYSTEM_OFFSET_MV = 12'hbb8;
  localparam logic [11:0] MIN_SYSTEM_STEP_MV = 12'h064;
  localparam logic [11:0] MIN_VBAT_HIGH_MV = 12'hb54;
  localparam logic [11:0] MIN_VBAT_LOW_MV = 12'h9c4;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } reg_rsp_type;

  typedef struct packed {
    logic out_ctrl;
    logic watchdog_kick;
    logic boost_output_en;
    logic charge_en;
    logic [2:0] min_system_voltage;
    logic min_vbat_sel;
  } cfg_a_type;

  typedef struct packed {
    logic pulse_control_en;
    logic [6:0] fast_charge_current;
  } cfg_b_type;

  typedef struct packed {
    logic adapter_plugged;
    logic detect_active;
    logic pulse_up;
    logic pulse_down;
  } sys_state_type;

  typedef struct packed {
    logic boost_output_en;
    logic charge_en;
    logic [2:0] min_system_voltage;
    logic min_vbat_sel;
    logic pulse_control_en;
    logic pulse_up;
    logic pulse_down;
    logic [6:0] fast_charge_current;
    logic [12:0] fast_charge_ma;
    logic [11:0] min_system_mv;
    logic [11:0] min_vbat_mv;
    logic adapter_present_out;
    logic data_select_out;
  } ctrl_out_type;

  typedef enum logic [1:0] {
    KICK_IDLE = 2'b01,
    KICK_WAIT = 2'b10
  } kick_state_type;

endpackage

// >>> rtl/current_code_clamp.sv
// fast charge current code clamp to the largest legal code
`timescale 1ns/1ps
`default_nettype none
module current_code_clamp
  (
  // raw code
  input wire logic [6:0] code_i,
  // stored code
  output logic [6:0] code_o
  );
  import charger_cfg_pkg::*;

  always_comb
  begin
    code_o = (code_i > FAST_CHARGE_CODE_MAX) ? FAST_CHARGE_CODE_MAX : code_i;
  end

endmodule
`default_nettype wire

// >>> rtl/watchdog_kick_tracker.sv
// watchdog kick bit: holds the restart request until the timer reports done
`timescale 1ns/1ps
`default_nettype none
module watchdog_kick_tracker
  (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic kick_i,
  input wire logic clear_i,
  input wire logic restart_done_i,
  // status
  output logic kick_pending_o
  );
  import charger_cfg_pkg::*;

  typedef struct packed {
    kick_state_type state;
    logic pending;
  } kick_regs_type;

  kick_regs_type st_reg;
  kick_regs_type st_next;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg.state)
      KICK_IDLE:
      begin
        if (kick_i && !clear_i)
        begin
          st_next.state = KICK_WAIT;
          st_next.pending = 1'b1;
        end
      end
      KICK_WAIT:
      begin
        // a fresh kick in the done cycle keeps the request alive
        if (clear_i)
        begin
          st_next.state = KICK_IDLE;
          st_next.pending = 1'b0;
        end
        else if (restart_done_i && !kick_i)
        begin
          st_next.state = KICK_IDLE;
          st_next.pending = 1'b0;
        end
      end
      default:
      begin
        st_next.state = KICK_IDLE;
        st_next.pending = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '{state: KICK_IDLE, pending: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign kick_pending_o = st_reg.pending;

endmodule
`default_nettype wire

// >>> verif/charger_cfg_properties.sv
// assertions on the charger configuration register ports
`timescale 1ns/1ps
`default_nettype none
module charger_cfg_properties
  (
  // watched ports
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire charger_cfg_pkg::reg_req_type req_i,
  input wire charger_cfg_pkg::reg_rsp_type rsp_o,
  input wire logic reg_reset_i,
  input wire logic wd_expire_i,
  input wire logic wd_restart_done_i,
  input wire logic wd_restart_o,
  input wire charger_cfg_pkg::sys_state_type sys_i,
  input wire charger_cfg_pkg::ctrl_out_type ctrl_o
  );
  import charger_cfg_pkg::*;
  // decoded outputs hold zeros in the first cycle after release
  logic live_reg;
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      live_reg <= 1'b0;
    else
      live_reg <= 1'b1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    req_i.wr || req_i.rd;
  endsequence
  sequence s_kick;
    req_i.wr && req_i.addr == CHARGER_CONFIG_A_ADDR && req_i.wdata[6]
      && !reg_reset_i && !wd_expire_i;
  endsequence
  a_ack_after_req: assert property (s_take |=> rsp_o.ack)
    else $error("no ack after request");
  a_no_spur_ack: assert property (!req_i.wr && !req_i.rd |=> !rsp_o.ack)
    else $error("ack without request");
  a_kick_raise: assert property (s_kick |=> wd_restart_o)
    else $error("kick did not raise restart");
  a_ma_scale: assert property (ctrl_o.fast_charge_ma ==
    13'(ctrl_o.fast_charge_current) * FAST_CHARGE_STEP_MA)
    else $error("charge current scaling wrong");
  a_code_clamp: assert property (ctrl_o.fast_charge_current <= 7'h3f)
    else $error("current code above clamp");
  a_zero_off: assert property (ctrl_o.fast_charge_current == 7'h00
    |-> !ctrl_o.charge_en)
    else $error("charging with zero code");
  a_sys_mv: assert property (live_reg |-> ctrl_o.min_system_mv ==
    MIN_SYSTEM_OFFSET_MV + 12'(ctrl_o.min_system_voltage) * 12'h064)
    else $error("system voltage scaling wrong");
  a_vbat_mv: assert property (live_reg |-> ctrl_o.min_vbat_mv ==
    (ctrl_o.min_vbat_sel ? 12'h9c4 : 12'hb54))
    else $error("battery threshold wrong");
  a_pulse_gate: assert property (ctrl_o.pulse_up || ctrl_o.pulse_down
    |-> ctrl_o.pulse_control_en)
    else $error("pulse passed while disabled");
  a_reset_dflt: assert property (reg_reset_i |=> ##1
    ctrl_o.fast_charge_current == 7'h20 && ctrl_o.min_system_voltage == 3'h5)
    else $error("register reset missed defaults");
  a_expire_dflt: assert property (wd_expire_i && !reg_reset_i |=> ##1
    !ctrl_o.boost_output_en && ctrl_o.charge_en)
    else $error("expiry missed defaults");
endmodule
bind charger_config_regs charger_cfg_properties charger_cfg_properties_i
  (.mclk_i, .rstn_i, .req_i, .rsp_o, .reg_reset_i, .wd_expire_i,
   .wd_restart_done_i, .wd_restart_o, .sys_i, .ctrl_o);
`default_nettype wire

// >>> verif/charger_host_model.sv
// host model issuing single-byte register reads and writes
`timescale 1ns/1ps
`default_nettype none
module charger_host_model
  (
  // register access
  input wire logic mclk_i,
  output charger_cfg_pkg::reg_req_type req_o,
  input wire charger_cfg_pkg::reg_rsp_type rsp_i
  );
  import charger_cfg_pkg::*;
  initial req_o = '0;
  // strobe for one edge; idle address and data lines show the inverse of the last value
  task automatic access(input logic wr, input logic [7:0] addr,
    input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge mclk_i);
    #1;
    req_o = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge mclk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    rdata = rsp_i.rdata;
  endtask
endmodule
`default_nettype wire

// >>> verif/charger_config_regs_test.sv
// self-checking bench for the charger configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); n_errors++; end end
module charger_config_regs_test;
  import charger_cfg_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  row_type rows [6] = '{'{8'h03, 8'hbf, 8'hbf}, '{8'h03, 8'h01, 8'h01},
    '{8'h04, 8'hff, 8'hbf}, '{8'h04, 8'h00, 8'h00},
    '{8'h04, 8'h40, 8'h3f}, '{8'h05, 8'hff, 8'h00}};
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic reg_reset_i = 1'b0;
  logic wd_expire_i = 1'b0;
  logic wd_restart_done_i = 1'b0;
  sys_state_type sys_i = '0;
  reg_req_type req_i;
  reg_rsp_type rsp_o;
  logic wd_restart_o;
  ctrl_out_type ctrl_o;
  ctrl_out_type ctrl_ds;
  logic [7:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 mclk_i = ~mclk_i;
  charger_host_model charger_host_model_i
    (.mclk_i, .req_o(req_i), .rsp_i(rsp_o));
  charger_config_regs #(.HAS_DATA_SELECT(1'b0)) charger_config_regs_i
    (.mclk_i, .rstn_i, .req_i, .rsp_o, .reg_reset_i, .wd_expire_i,
     .wd_restart_done_i, .wd_restart_o, .sys_i, .ctrl_o);
  charger_config_regs #(.HAS_DATA_SELECT(1'b1)) charger_config_regs_ds_i
    (.mclk_i, .rstn_i, .req_i, .rsp_o(), .reg_reset_i, .wd_expire_i,
     .wd_restart_done_i, .wd_restart_o(), .sys_i, .ctrl_o(ctrl_ds));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    charger_host_model_i.access(1'b1, a, d, rd);
  endtask
  task automatic rdr(input logic [7:0] a);
    charger_host_model_i.access(1'b0, a, 8'h00, rd);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    tick(3);
    rstn_i = 1'b1;
    rdr(8'h03);
    `CHK("charger_config_a reset", 8'h1a, rd)
    rdr(8'h04);
    `CHK("charge_current_ctrl reset", 8'h20, rd)
    `CHK("sys mv", 12'd3500, ctrl_o.min_system_mv)
    `CHK("chg ma", 13'd2048, ctrl_o.fast_charge_ma)
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdr(rows[i].a);
      `CHK("readback", rows[i].e, rd)
    end
    // adapter output in boost mode, then with adapter plugged
    wr(8'h03, 8'hba);
    tick(2);
    `CHK("adapter out", 1'b1, ctrl_o.adapter_present_out)
    `CHK("charge en", 1'b1, ctrl_o.charge_en)
    `CHK("boost", 1'b1, ctrl_o.boost_output_en)
    `CHK("data_select_out boost", 1'b1, ctrl_ds.data_select_out)
    `CHK("data_select_out unused", 1'b0, ctrl_o.data_select_out)
    `CHK("adapter unused", 1'b0, ctrl_ds.adapter_present_out)
    sys_i.adapter_plugged = 1'b1;
    tick(2);
    `CHK("adapter plugged", 1'b0, ctrl_o.adapter_present_out)
    `CHK("data_select_out plugged", 1'b1, ctrl_ds.data_select_out)
    sys_i.adapter_plugged = 1'b0;
    sys_i.pulse_up = 1'b1;
    sys_i.pulse_down = 1'b1;
    tick(2);
    `CHK("pulse gated", 1'b0, ctrl_o.pulse_up)
    `CHK("pulse dn gated", 1'b0, ctrl_o.pulse_down)
    wr(8'h04, 8'h85);
    tick(2);
    `CHK("pulse on", 1'b1, ctrl_o.pulse_up)
    `CHK("pulse dn on", 1'b1, ctrl_o.pulse_down)
    `CHK("chg ma", 13'd320, ctrl_o.fast_charge_ma)
    sys_i.pulse_up = 1'b0;
    sys_i.pulse_down = 1'b0;
    // kick stays pending until the timer reports done
    wr(8'h03, 8'h5a);
    tick(3);
    `CHK("kick held", 1'b1, wd_restart_o)
    wd_restart_done_i = 1'b1;
    tick(1);
    wd_restart_done_i = 1'b0;
    tick(2);
    `CHK("kick done", 1'b0, wd_restart_o)
    rdr(8'h03);
    `CHK("kick bit", 8'h1a, rd)
    sys_i.adapter_plugged = 1'b1;
    tick(2);
    `CHK("data_select_out no force", 1'b0, ctrl_ds.data_select_out)
    sys_i.detect_active = 1'b1;
    tick(2);
    `CHK("data_select_out detect", 1'b1, ctrl_ds.data_select_out)
    sys_i.adapter_plugged = 1'b0;
    sys_i.detect_active = 1'b0;
    wr(8'h03, 8'hbb);
    wd_expire_i = 1'b1;
    tick(1);
    wd_expire_i = 1'b0;
    rdr(8'h03);
    `CHK("expiry charger_config_a", 8'h9b, rd)
    rdr(8'h04);
    `CHK("expiry charge_current_ctrl", 8'h20, rd)
    `CHK("vbat mv", 12'h9c4, ctrl_o.min_vbat_mv)
    `CHK("data_select_out battery", 1'b0, ctrl_ds.data_select_out)
    wr(8'h03, 8'hbb);
    reg_reset_i = 1'b1;
    tick(1);
    reg_reset_i = 1'b0;
    rdr(8'h03);
    `CHK("reg reset", 8'h1a, rd)
    wr(8'h04, 8'h11);
    rstn_i = 1'b0;
    tick(2);
    rstn_i = 1'b1;
    rdr(8'h04);
    `CHK("second reset", 8'h20, rd)
    results();
  end
endmodule
`default_nettype wire
